//--- logic/meter_cfg_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef METER_CFG_MAP_SVH
`define METER_CFG_MAP_SVH
`define OFS_GAIN        12'h000
`define OFS_HPF         12'h004
`define OFS_CONFIG      12'h008
`define OFS_DIV1        12'h00C
`define OFS_DIV2        12'h010
`define OFS_DIV3        12'h014
`define OFS_NOMINAL_VOLTAGE_LEVEL      12'h018
`define OFS_PMODE       12'h01C
`define OFS_COMP        12'h020
`define OFS_RUN         12'h024
`define OFS_ACTIVE_ENERGY_THRESHOLD_LO     12'h028
`define OFS_ACTIVE_ENERGY_THRESHOLD_HI     12'h02C
`define OFS_REACTIVE_ENERGY_THRESHOLD_LO   12'h030
`define OFS_REACTIVE_ENERGY_THRESHOLD_HI   12'h034
`define OFS_APPARENT_ENERGY_THRESHOLD_LO    12'h038
`define OFS_APPARENT_ENERGY_THRESHOLD_HI    12'h03C
`define OFS_STATUS      12'h040
`define OFS_E_PHA       12'h044
`define OFS_E_PHB       12'h048
`define OFS_E_PHC       12'h04C
`define OFS_PHASE_EN    12'h050
`define BIT_INTEG       0
`define BIT_OUT1_DIS    9
`define BIT_OUT2_DIS    10
`define BIT_OUT3_DIS    11
`define COMP_PHASE_MAP  16'h3911
`define RST_DIV         16'h0001
`define RST_PMODE       16'h0000
`define RST_COMP        16'h01FF
`define PULSE_WIDTH_NS  80
`define CLK_PERIOD_NS   40
`define PULSE_CYC       ((`PULSE_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

//--- logic/meter_cfg_pkg.sv
// types shared by the meter configuration logic
`default_nettype none
package meter_cfg_pkg;
  typedef enum logic [2:0] {
    ST_POWERDOWN = 3'b001,
    ST_NORMAL    = 3'b010,
    ST_RUNNING   = 3'b100
  } power_state_t;
  typedef logic [23:0] word24_t;
endpackage
`default_nettype wire

//--- logic/pulse_converter.sv
// energy-to-frequency converter for one pulse output
`include "meter_cfg_map.svh"
`default_nettype none
module pulse_converter #(
  parameter int ACC_W = 32
) (
  input  wire logic             core_clk,      // clock
  input  wire logic             srst,          // sync reset
  input  wire logic             run,           // engine running
  input  wire logic             out_dis,       // pin disable
  input  wire logic [15:0]      pulse_divider, // energy per pulse
  input  wire logic [15:0]      energy_inc,    // energy this tick
  input  wire logic             energy_vld,    // energy tick
  output logic                  pulse_out      // pulse pin
);
  logic [ACC_W-1:0] acc_r, acc_nxt;
  logic [3:0]       wid_r, wid_nxt;
  logic             pls_r, pls_nxt;
  logic [ACC_W-1:0] sum;
  logic [ACC_W-1:0] lim;

  if (ACC_W < 17) begin : g_bad_acc
    $error("ACC_W too small");
  end
  // the pulse width counter is only four bits wide
  if (`PULSE_CYC < 1 || `PULSE_CYC > 16) begin : g_bad_wid
    $error("pulse width out of range");
  end

  always_comb begin
    sum     = acc_r + ACC_W'(energy_inc);
    // a zero divider is treated as one so the output never stalls
    lim     = (pulse_divider == 16'h0000) ? ACC_W'(1) : ACC_W'(pulse_divider);
    acc_nxt = acc_r;
    wid_nxt = wid_r;
    pls_nxt = pls_r;
    if (wid_r != 4'h0) begin
      wid_nxt = wid_r - 4'h1;
    end else begin
      pls_nxt = 1'b0;
    end
    if (run && energy_vld) begin
      if (sum >= lim) begin
        acc_nxt = sum - lim;
        if (!out_dis) begin
          pls_nxt = 1'b1;
          wid_nxt = 4'(`PULSE_CYC - 1);
        end
      end else begin
        acc_nxt = sum;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      acc_r <= '0;
      wid_r <= 4'h0;
      pls_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      wid_r <= wid_nxt;
      pls_r <= pls_nxt;
    end
  end

  assign pulse_out = pls_r;
endmodule
`default_nettype wire

//--- logic/meter_cfg.sv
// configuration, power mode and pulse routing of a three-phase meter
`include "meter_cfg_map.svh"
`default_nettype none
// Overview of operation
// - each divider sets how much energy makes one pulse on its output
// - pin hi low and pin lo high select the normal power state
// - highpass disable written zero keeps the filter in the data path
// - config bit 0 enables integrator; zero bypasses it
// - pulse mode bits 9..11 each disable their own pulse output
// - computation mode 0x3911 routes phases A, B, C to outputs 1..3
// - writing one to run starts the processing engine
// - each energy threshold is 48 bits, written as two 24-bit halves
module meter_cfg
#(
  parameter int ACC_W = 32
) (
  input  wire logic                 core_clk,          // 25 MHz clock
  input  wire logic                 srst,              // sync reset
  input  wire logic                 psel,              // apb select
  input  wire logic                 penable,           // apb enable
  input  wire logic                 pwrite,            // apb direction
  input  wire logic [11:0]          paddr,             // apb byte address
  input  wire logic [31:0]          pwdata,            // apb write data
  output logic      [31:0]          prdata,            // apb read data
  output logic                      pready,            // apb ready
  output logic                      pslverr,           // apb error
  input  wire logic                 power_mode_pin_hi, // mode pin 1
  input  wire logic                 power_mode_pin_lo, // mode pin 0
  input  wire logic                 energy_vld,        // energy tick
  input  wire logic [15:0]          energy_pha,        // phase A energy
  input  wire logic [15:0]          energy_phb,        // phase B energy
  input  wire logic [15:0]          energy_phc,        // phase C energy
  output logic                      pulse_out_first,   // pulse pin 1
  output logic                      pulse_out_second,  // pulse pin 2
  output logic                      pulse_out_third,   // pulse pin 3
  output logic                      highpass_en,       // filter in path
  output logic                      integrator_enable, // integrator on
  output logic      [31:0]          gain_setting,      // pga gains
  output logic      [31:0]          nominal_voltage_level, // level value
  output logic      [47:0]          active_energy_threshold,   // 48 bit
  output logic      [47:0]          reactive_energy_threshold, // 48 bit
  output logic      [47:0]          apparent_energy_threshold, // 48 bit
  output var meter_cfg_pkg::power_state_t power_state   // power state
);
  import meter_cfg_pkg::*;

  // a 16-bit divider must fit the accumulator; wider than 64 bits only
  // costs area
  if (ACC_W < 17 || ACC_W > 64) begin : g_bad_acc
    $error("ACC_W out of range");
  end

  // mode pins come from outside, two flops before use
  logic [1:0] pm_s1_r, pm_s2_r;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pm_s1_r <= 2'b00;
      pm_s2_r <= 2'b00;
    end else begin
      pm_s1_r <= {power_mode_pin_hi, power_mode_pin_lo};
      pm_s2_r <= pm_s1_r;
    end
  end

  logic [31:0] gain_r, gain_nxt;
  logic        hpf_dis_r, hpf_dis_nxt;
  logic [31:0] config_r, config_nxt;
  logic [15:0] div_r [3], div_nxt [3];
  logic [31:0] nominal_voltage_level_r, nominal_voltage_level_nxt;
  logic [15:0] pmode_r, pmode_nxt;
  logic [15:0] comp_r, comp_nxt;
  logic        run_r, run_nxt;
  word24_t     thr_r [6], thr_nxt [6];
  logic [31:0] prdata_r, prdata_nxt;

  logic        normal_pins;
  logic        wr_acc, rd_acc, hit;
  logic [31:0] rd_val;

  // an unknown select feeds no energy, so a bad code gives no pulses
  function automatic logic [15:0] sel_phase(input logic [1:0] ph,
      input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    case (ph)
      2'd0:    sel_phase = a;
      2'd1:    sel_phase = b;
      2'd2:    sel_phase = c;
      default: sel_phase = 16'h0000;
    endcase
  endfunction

  // hi low with lo high is the only pin pair that powers the meter up
  assign normal_pins = (pm_s2_r == 2'b01);
  // every transfer completes in its first access cycle
  assign pready  = 1'b1;
  // writes land at the access edge only, never during setup
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && !pwrite;

  // read decode, data registered during setup so access phase is 0 wait
  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      `OFS_GAIN:      rd_val = gain_r;
      `OFS_HPF:       rd_val = {31'h0, hpf_dis_r};
      `OFS_CONFIG:    rd_val = config_r;
      `OFS_DIV1:      rd_val = {16'h0000, div_r[0]};
      `OFS_DIV2:      rd_val = {16'h0000, div_r[1]};
      `OFS_DIV3:      rd_val = {16'h0000, div_r[2]};
      `OFS_NOMINAL_VOLTAGE_LEVEL:    rd_val = nominal_voltage_level_r;
      `OFS_PMODE:     rd_val = {16'h0000, pmode_r};
      `OFS_COMP:      rd_val = {16'h0000, comp_r};
      `OFS_RUN:       rd_val = {31'h0, run_r};
      `OFS_ACTIVE_ENERGY_THRESHOLD_LO:   rd_val = {8'h00, thr_r[0]};
      `OFS_ACTIVE_ENERGY_THRESHOLD_HI:   rd_val = {8'h00, thr_r[1]};
      `OFS_REACTIVE_ENERGY_THRESHOLD_LO: rd_val = {8'h00, thr_r[2]};
      `OFS_REACTIVE_ENERGY_THRESHOLD_HI: rd_val = {8'h00, thr_r[3]};
      `OFS_APPARENT_ENERGY_THRESHOLD_LO:  rd_val = {8'h00, thr_r[4]};
      `OFS_APPARENT_ENERGY_THRESHOLD_HI:  rd_val = {8'h00, thr_r[5]};
      `OFS_STATUS:    rd_val = {29'h0, power_state};
      default:        hit = 1'b0;
    endcase
  end

  // unmapped offsets answer with an error and change nothing
  assign pslverr = psel && penable && !hit;

  always_comb begin
    gain_nxt   = gain_r;
    hpf_dis_nxt = hpf_dis_r;
    config_nxt = config_r;
    nominal_voltage_level_nxt = nominal_voltage_level_r;
    pmode_nxt  = pmode_r;
    comp_nxt   = comp_r;
    run_nxt    = run_r;
    prdata_nxt = prdata_r;
    for (int i = 0; i < 3; i++) begin
      div_nxt[i] = div_r[i];
    end
    for (int i = 0; i < 6; i++) begin
      thr_nxt[i] = thr_r[i];
    end
    if (rd_acc && !penable) begin
      prdata_nxt = rd_val;
    end

    // each threshold half lands alone; the 48-bit copy joins both halves
    if (wr_acc) begin
      case (paddr)
        `OFS_GAIN:      gain_nxt = pwdata;
        `OFS_HPF:       hpf_dis_nxt = pwdata[0];
        `OFS_CONFIG:    config_nxt = pwdata;
        `OFS_DIV1:      div_nxt[0] = pwdata[15:0];
        `OFS_DIV2:      div_nxt[1] = pwdata[15:0];
        `OFS_DIV3:      div_nxt[2] = pwdata[15:0];
        `OFS_NOMINAL_VOLTAGE_LEVEL:    nominal_voltage_level_nxt = pwdata;
        `OFS_PMODE:     pmode_nxt = pwdata[15:0];
        `OFS_COMP:      comp_nxt = pwdata[15:0];
        // only the value one starts the engine, anything else stops it
        `OFS_RUN:       run_nxt = (pwdata == 32'h0000_0001);
        `OFS_ACTIVE_ENERGY_THRESHOLD_LO:   thr_nxt[0] = pwdata[23:0];
        `OFS_ACTIVE_ENERGY_THRESHOLD_HI:   thr_nxt[1] = pwdata[23:0];
        `OFS_REACTIVE_ENERGY_THRESHOLD_LO: thr_nxt[2] = pwdata[23:0];
        `OFS_REACTIVE_ENERGY_THRESHOLD_HI: thr_nxt[3] = pwdata[23:0];
        `OFS_APPARENT_ENERGY_THRESHOLD_LO:  thr_nxt[4] = pwdata[23:0];
        `OFS_APPARENT_ENERGY_THRESHOLD_HI:  thr_nxt[5] = pwdata[23:0];
        default: ;
      endcase
    end
  end

  // dividers leave reset at one so an unset pin still counts
  always_ff @(posedge core_clk) begin
    if (srst) begin
      gain_r    <= 32'h0000_0000;
      hpf_dis_r <= 1'b0;
      config_r  <= 32'h0000_0000;
      nominal_voltage_level_r  <= 32'h0000_0000;
      pmode_r   <= `RST_PMODE;
      comp_r    <= `RST_COMP;
      run_r     <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      for (int i = 0; i < 3; i++) begin
        div_r[i] <= `RST_DIV;
      end
      for (int i = 0; i < 6; i++) begin
        thr_r[i] <= 24'h00_0000;
      end
    end else begin
      gain_r    <= gain_nxt;
      hpf_dis_r <= hpf_dis_nxt;
      config_r  <= config_nxt;
      nominal_voltage_level_r  <= nominal_voltage_level_nxt;
      pmode_r   <= pmode_nxt;
      comp_r    <= comp_nxt;
      run_r     <= run_nxt;
      prdata_r  <= prdata_nxt;
      for (int i = 0; i < 3; i++) begin
        div_r[i] <= div_nxt[i];
      end
      for (int i = 0; i < 6; i++) begin
        thr_r[i] <= thr_nxt[i];
      end
    end
  end

  // read data stands until the next read setup
  assign prdata = prdata_r;

  // power state follows the pins; running needs run set as well
  // losing the normal pins drops to power-down whether run is set or not
  power_state_t ps_r, ps_nxt;
  always_comb begin
    case (ps_r)
      ST_POWERDOWN: ps_nxt = normal_pins ? ST_NORMAL : ST_POWERDOWN;
      ST_NORMAL: begin
        if (!normal_pins) ps_nxt = ST_POWERDOWN;
        else if (run_r) ps_nxt = ST_RUNNING;
        else ps_nxt = ST_NORMAL;
      end
      ST_RUNNING: begin
        if (!normal_pins) ps_nxt = ST_POWERDOWN;
        else if (!run_r) ps_nxt = ST_NORMAL;
        else ps_nxt = ST_RUNNING;
      end
      default: ps_nxt = ST_POWERDOWN;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ps_r <= ST_POWERDOWN;
    end else begin
      ps_r <= ps_nxt;
    end
  end

  assign power_state = ps_r;

  // configuration outputs registered from their sources
  // the copies lag the register file by one edge and never glitch
  always_ff @(posedge core_clk) begin
    if (srst) begin
      highpass_en               <= 1'b0;
      integrator_enable         <= 1'b0;
      gain_setting              <= 32'h0000_0000;
      nominal_voltage_level     <= 32'h0000_0000;
      active_energy_threshold   <= 48'h0000_0000_0000;
      reactive_energy_threshold <= 48'h0000_0000_0000;
      apparent_energy_threshold <= 48'h0000_0000_0000;
    end else begin
      highpass_en               <= !hpf_dis_r;
      integrator_enable         <= config_r[`BIT_INTEG];
      gain_setting              <= gain_r;
      nominal_voltage_level     <= nominal_voltage_level_r;
      active_energy_threshold   <= {thr_r[1], thr_r[0]};
      reactive_energy_threshold <= {thr_r[3], thr_r[2]};
      apparent_energy_threshold <= {thr_r[5], thr_r[4]};
    end
  end

  // phase routing: comp_r[8:0] holds three 3-bit phase selects, one per out
  // a select of 1 = A, 2 = B, 4 = C; 0x3911 gives A, B, C in order
  logic [2:0]  out_pins;
  logic [15:0] route_e [3];
  logic        running;
  assign running = (ps_r == ST_RUNNING);

  function automatic logic [1:0] phase_of(input logic [2:0] sel);
    case (sel)
      3'b001:  phase_of = 2'd0;
      3'b010:  phase_of = 2'd1;
      3'b100:  phase_of = 2'd2;
      default: phase_of = 2'd3;
    endcase
  endfunction

  // a disabled pin still drains its accumulator, so enabling it later
  // does not release a burst of stored pulses
  for (genvar g = 0; g < 3; g++) begin : g_out
    assign route_e[g] = sel_phase(phase_of(comp_r[3*g +: 3]),
                                  energy_pha, energy_phb, energy_phc);
    pulse_converter #(.ACC_W(ACC_W)) u_conv (
      .core_clk      (core_clk),
      .srst          (srst),
      .run           (running),
      .out_dis       (pmode_r[`BIT_OUT1_DIS + g]),
      .pulse_divider (div_r[g]),
      .energy_inc    (route_e[g]),
      .energy_vld    (energy_vld),
      .pulse_out     (out_pins[g])
    );
  end

  assign pulse_out_first  = out_pins[0];
  assign pulse_out_second = out_pins[1];
  assign pulse_out_third  = out_pins[2];
endmodule
`default_nettype wire

//--- testbench/meter_cfg_props.sv
// assertion checker for the meter configuration block
`include "meter_cfg_map.svh"
`default_nettype none
module meter_cfg_props (
  input wire logic        core_clk,          // clock
  input wire logic        srst,              // reset
  input wire logic        psel,              // select
  input wire logic        penable,           // enable
  input wire logic        pwrite,            // direction
  input wire logic [11:0] paddr,             // address
  input wire logic [31:0] pwdata,            // wdata
  input wire logic        pready,            // ready
  input wire logic        power_mode_pin_lo, // pin 0
  input wire logic        power_mode_pin_hi, // pin 1
  input wire logic        pulse_out_first,   // out 1
  input wire logic        pulse_out_second,  // out 2
  input wire logic        pulse_out_third,   // out 3
  input wire logic        highpass_en,       // filter
  input wire logic        integrator_enable, // integ
  input wire logic [47:0] active_energy_threshold,   // thr
  input wire logic [47:0] reactive_energy_threshold, // thr
  input wire meter_cfg_pkg::power_state_t power_state // state
);
  import meter_cfg_pkg::*;
  logic       wr;
  logic [2:0] dis_r;
  logic [2:0] dis_nxt;
  assign wr = psel && penable && pwrite && pready;
  always_comb begin
    dis_nxt = dis_r;
    if (wr && paddr == `OFS_PMODE)
      dis_nxt = pwdata[11:9];
  end
  always_ff @(posedge core_clk) begin
    if (srst)
      dis_r <= 3'b000;
    else
      dis_r <= dis_nxt;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence pins_normal;
    !power_mode_pin_hi && power_mode_pin_lo;
  endsequence
  sequence held2(logic p);
    p [*2] ##1 !p;
  endsequence
  normal_entry_a: assert property (pins_normal [*5] |->
    power_state != ST_POWERDOWN) else $error("no normal state");
  hpf_follow_a: assert property (wr && paddr == `OFS_HPF |-> ##2
    highpass_en != $past(pwdata[0], 2)) else $error("filter path wrong");
  integ_follow_a: assert property (wr && paddr == `OFS_CONFIG |-> ##2
    integrator_enable == $past(pwdata[0], 2)) else $error("integ wrong");
  run_start_a: assert property (power_state == ST_NORMAL && wr &&
    paddr == `OFS_RUN && pwdata == 32'h0000_0001 |->
    ##[1:2] power_state == ST_RUNNING) else $error("engine not started");
  out_gate_a: assert property ((dis_r & $past(dis_r, 3) &
    {pulse_out_third, pulse_out_second, pulse_out_first}) == 3'b000)
    else $error("disabled pin pulsed");
  pulse_width_a: assert property ($rose(pulse_out_first) |->
    held2(pulse_out_first)) else $error("pulse width wrong");
  thr_hi_a: assert property (wr && paddr == `OFS_ACTIVE_ENERGY_THRESHOLD_HI |-> ##2
    active_energy_threshold == {$past(pwdata[23:0], 2),
    $past(active_energy_threshold[23:0], 2)}) else $error("hi half wrong");
  thr_lo_a: assert property (wr && paddr == `OFS_REACTIVE_ENERGY_THRESHOLD_LO |-> ##2
    reactive_energy_threshold == {$past(reactive_energy_threshold[47:24], 2),
    $past(pwdata[23:0], 2)}) else $error("lo half wrong");
endmodule
bind meter_cfg meter_cfg_props chk (.core_clk, .srst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .power_mode_pin_lo, .power_mode_pin_hi,
  .pulse_out_first, .pulse_out_second, .pulse_out_third, .highpass_en,
  .integrator_enable, .active_energy_threshold, .reactive_energy_threshold,
  .power_state);
`default_nettype wire

//--- testbench/meter_host.sv
// host model: apb master that runs the meter start-up sequence
`include "meter_cfg_map.svh"
`default_nettype none
module meter_host #(
  parameter int V_FS = 300, // full scale volts, plain default
  parameter int V_N  = 150  // nominal volts, plain default
) (
  input  wire logic        core_clk, // clock
  output logic             psel,     // select
  output logic             penable,  // enable
  output logic             pwrite,   // direction
  output logic [11:0]      paddr,    // address
  output logic [31:0]      pwdata,   // wdata
  input  wire logic [31:0] prdata,   // rdata
  input  wire logic        pready,   // ready
  input  wire logic        pslverr   // error
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hung;
  initial {hung, psel, penable, pwrite, paddr, pwdata} = '0;
  // called just after a rising edge; an idle edge follows every transfer
  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      hung = 1'b1;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    xfer(a, 1'b1, d, q, e);
  endtask
  // pins must already select normal power before this is called
  task automatic start_up();
    wr(`OFS_GAIN, 32'h0000_0000);
    wr(`OFS_HPF, 32'h0000_0000);
    wr(`OFS_CONFIG, 32'h0000_0000);
    for (int i = 0; i < 3; i++)
      wr(12'(`OFS_DIV1 + 4 * i), 32'h0000_0001);
    wr(`OFS_NOMINAL_VOLTAGE_LEVEL, 32'(V_FS * 491520 / V_N));
    wr(`OFS_PMODE, 32'h0000_0000);
    wr(`OFS_COMP, 32'h0000_3911);
    wr(`OFS_RUN, 32'h0000_0001);
  endtask
endmodule
`default_nettype wire

//--- testbench/test_meter_cfg.sv
// self-checking bench for the meter configuration block
`include "meter_cfg_map.svh"
`default_nettype none
module test_meter_cfg;
  timeunit 1ns;
  timeprecision 1ns;
  import meter_cfg_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] d; int s; logic [47:0] x;}
    row_t;
  logic         core_clk, srst, psel, penable, pwrite, pready, pslverr;
  logic         power_mode_pin_hi, power_mode_pin_lo, energy_vld;
  logic         pulse_out_first, pulse_out_second, pulse_out_third;
  logic         highpass_en, integrator_enable;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, gain_setting, nominal_voltage_level, q;
  logic [15:0]  energy_pha, energy_phb, energy_phc;
  logic [47:0]  active_energy_threshold, reactive_energy_threshold;
  logic [47:0]  apparent_energy_threshold;
  logic         e;
  power_state_t power_state;
  int           error_cnt = 0;
  int           checks = 0;
  int           pc[3];
  row_t rows [10] = '{
    '{`OFS_GAIN,      32'h1234_5678, 0, 48'h0000_1234_5678},
    '{`OFS_HPF,       32'h0000_0001, 1, 48'h0000_0000_0000},
    '{`OFS_HPF,       32'h0000_0000, 1, 48'h0000_0000_0001},
    '{`OFS_CONFIG,    32'h0000_0001, 2, 48'h0000_0000_0001},
    '{`OFS_CONFIG,    32'h0000_0000, 2, 48'h0000_0000_0000},
    '{`OFS_NOMINAL_VOLTAGE_LEVEL,    32'h000F_0000, 3, 48'h0000_000F_0000},
    '{`OFS_ACTIVE_ENERGY_THRESHOLD_LO,   32'hFFAB_CDEF, 4, 48'h0000_00AB_CDEF},
    '{`OFS_ACTIVE_ENERGY_THRESHOLD_HI,   32'h0012_3456, 4, 48'h1234_56AB_CDEF},
    '{`OFS_REACTIVE_ENERGY_THRESHOLD_LO, 32'h00FE_DCBA, 5, 48'h0000_00FE_DCBA},
    '{`OFS_APPARENT_ENERGY_THRESHOLD_LO,  32'h0000_0001, 6, 48'h0000_0000_0001}
  };
  meter_cfg uut (.*);
  meter_host host (.*);
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge pulse_out_first) pc[0]++;
  always @(posedge pulse_out_second) pc[1]++;
  always @(posedge pulse_out_third) pc[2]++;
  function automatic logic [47:0] obs(input int s);
    case (s)
      0: return 48'(gain_setting);
      1: return 48'(highpass_en);
      2: return 48'(integrator_enable);
      3: return 48'(nominal_voltage_level);
      4: return active_energy_threshold;
      5: return reactive_energy_threshold;
      default: return apparent_energy_threshold;
    endcase
  endfunction
  task automatic chk(input string n, input logic [47:0] x,
                     input logic [47:0] g);
    checks++;
    if (g !== x) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic results();
    if (host.hung)
      error_cnt++;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wait_state(input power_state_t s);
    int n;
    n = 0;
    while (power_state !== s && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    chk("power state", 48'(s), 48'(power_state));
  endtask
  // ticks spaced wider than a pulse so that pulses never merge
  task automatic run_ticks(input int x0, input int x1, input int x2);
    pc = '{0, 0, 0};
    repeat (12) begin
      energy_vld <= 1'b1;
      @(posedge core_clk);
      energy_vld <= 1'b0;
      repeat (5) @(posedge core_clk);
    end
    repeat (5) @(posedge core_clk);
    chk("pulses out 1", 48'(x0), 48'(pc[0]));
    chk("pulses out 2", 48'(x1), 48'(pc[1]));
    chk("pulses out 3", 48'(x2), 48'(pc[2]));
  endtask
  initial begin
    {srst, power_mode_pin_hi, power_mode_pin_lo, energy_vld} = 4'b1100;
    {energy_pha, energy_phb, energy_phc} = {16'h0001, 16'h0002, 16'h0003};
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    host.xfer(`OFS_DIV1, 1'b0, 32'h0000_0000, q, e);
    chk("divider reset", 48'h1, 48'(q));
    host.xfer(`OFS_COMP, 1'b0, 32'h0000_0000, q, e);
    chk("routing reset", 48'h1FF, 48'(q));
    host.xfer(12'hFFC, 1'b1, 32'hFFFF_FFFF, q, e);
    chk("unmapped write", 48'h1, 48'(e));
    host.xfer(12'hFFC, 1'b0, 32'h0000_0000, q, e);
    chk("unmapped read", 48'h0, 48'(q));
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].d);
      // output copies follow one edge after the write lands
      @(posedge core_clk);
      chk($sformatf("row %0d", i), rows[i].x, obs(rows[i].s));
    end
    repeat (8) @(posedge core_clk);
    chk("other pin mode", 48'(ST_POWERDOWN), 48'(power_state));
    power_mode_pin_hi <= 1'b0;
    power_mode_pin_lo <= 1'b1;
    wait_state(ST_NORMAL);
    host.start_up();
    wait_state(ST_RUNNING);
    for (int i = 0; i < 3; i++)
      host.wr(12'(`OFS_DIV1 + 4 * i), 32'h0000_0006);
    run_ticks(2, 4, 6);
    host.wr(`OFS_PMODE, 32'h0000_0400);
    run_ticks(2, 0, 6);
    results();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    results();
  end
endmodule
`default_nettype wire
